// ===== crg_pkg.sv
// Constants, masks and types for the charger control and status registers
// How it works
// - Battery target code 000..111 picks 8.15V..13.05V, default 001.
// - Input limit code weights 400/200/100mV over 4.1V, default 4.4V.
// - Timeout code 00 off, then 6h, 12h, 24h; default 24h.
// - Charge current is 50mA per step, default 0x18; zero stops charging.
// - Switching frequency 500k..1.5MHz, default 1MHz; watchdog leaves it alone.
// - Termination and precharge currents: 200/100/50mA over 50mA, default 100mA.
// - Hot threshold off/45/55/60C default 45; cold off/0/-5/-10C default 0.
// - Cell balance switches default off; cleared on cell undervoltage or mode 00.
// - Balance mode off/auto/host/reserved, default auto; decoder low or >12V clears.
// - Charge and termination enables default on; watchdog enable default off.
// - Timer stretch bit halves safety timer rate while limiting; default off.
// - Thermal regulation select: 0 is 130C, 1 is 145C, default 145C.
// - Balance difference, stop and start voltage selects all default to zero.
// - Timer restart and watchdog restart writes clear their faults.
// - Register reset command restores every field that lists it.
// - Fields go to defaults on reset, watchdog, and while input absent.
// - Read-only charge phase, input limiting and thermal regulation flags.
// - Input present after 256ms above lockout; adapter good after 30ms.
// - Overvoltage, overtemperature, NTC, battery faults follow their conditions.
// - Charge timeout fault and watchdog fault clear on their listed events.
// - Six interrupt request flags, each cleared by writing one.
// - Eight interrupt enables default one; zero disables that interrupt.
// - Enabled request rising sends one 0.512ms low pulse on interrupt output.
// - Watchdog expiry after 20s charging restores fields and sets fault.
// - I2C target at 0x6B; bus ignored for 1ms after power-up or enable.
package crg_pkg;

  localparam logic [6:0] CRG_I2C_ADDR = 7'h6b;

  localparam logic [7:0] CRG_OFS_VOLTAGE_TARGETS = 8'h00;
  localparam logic [7:0] CRG_OFS_TIMER_AND_CURRENT = 8'h01;
  localparam logic [7:0] CRG_OFS_FREQ_AND_SMALL_CURRENTS = 8'h02;
  localparam logic [7:0] CRG_OFS_THERMISTOR_AND_BALANCE = 8'h03;
  localparam logic [7:0] CRG_OFS_CHARGE_ENABLES = 8'h04;
  localparam logic [7:0] CRG_OFS_BALANCE_AND_COMMANDS = 8'h05;
  localparam logic [7:0] CRG_OFS_CHARGE_STATE = 8'h06;
  localparam logic [7:0] CRG_OFS_FAULT_FLAGS = 8'h07;
  localparam logic [7:0] CRG_OFS_INTERRUPT_REQUESTS = 8'h08;
  localparam logic [7:0] CRG_OFS_INTERRUPT_ENABLES = 8'h09;

  // Index 0 is voltage_targets, index 5 balance_and_commands
  localparam logic [5:0][7:0] CRG_RESET =
    {8'h00, 8'h64, 8'h51, 8'h89, 8'hd8, 8'h2c};
  localparam logic [5:0][7:0] CRG_WMASK =
    {8'hf0, 8'h7c, 8'hff, 8'hff, 8'hff, 8'hfc};
  localparam logic [5:0][7:0] CRG_WDMASK =
    {8'hf0, 8'h6c, 8'hff, 8'h3f, 8'hff, 8'hfc};
  localparam logic [5:0][7:0] CRG_VINMASK =
    {8'h00, 8'h6c, 8'hf0, 8'hff, 8'hff, 8'hfc};
  localparam logic [7:0] CRG_IRQ_EN_RESET = 8'hff;
  localparam logic [7:0] CRG_IRQ_WMASK = 8'hfc;

  localparam int CRG_POS_TIMER_RST = 2;
  localparam int CRG_POS_WATCHDOG_RESTART_COMMAND = 1;
  localparam int CRG_POS_REG_RST = 0;
  localparam int CRG_POS_CHARGE_ENABLE_BIT = 6;
  localparam int CRG_POS_WATCHDOG_ENABLE_BIT = 4;
  localparam int CRG_POS_BAL1 = 3;
  localparam int CRG_POS_BAL0 = 2;
  localparam int CRG_POS_TARGET_HI = 7;
  localparam int CRG_POS_IRQ_CHG_EN = 1;
  localparam int CRG_POS_IRQ_WD_EN = 0;

  localparam longint unsigned CRG_CLK_HZ = 64'd125000000;
  localparam longint unsigned CRG_INPUT_PRESENT_FLAG_MS = 64'd256;
  localparam longint unsigned CRG_ADAPTER_GOOD_MS = 64'd30;
  localparam longint unsigned CRG_WATCHDOG_S = 64'd20;
  localparam longint unsigned CRG_INT_PULSE_US = 64'd512;
  localparam longint unsigned CRG_HOST_WAIT_MS = 64'd1;

  localparam int unsigned CRG_INPUT_PRESENT_FLAG_CYC =
    32'((CRG_CLK_HZ * CRG_INPUT_PRESENT_FLAG_MS + 64'd999) / 64'd1000);
  localparam int unsigned CRG_ADAPTER_GOOD_CYC =
    32'((CRG_CLK_HZ * CRG_ADAPTER_GOOD_MS + 64'd999) / 64'd1000);
  localparam int unsigned CRG_WATCHDOG_CYC = 32'(CRG_CLK_HZ * CRG_WATCHDOG_S);
  localparam int unsigned CRG_INT_PULSE_CYC =
    32'((CRG_CLK_HZ * CRG_INT_PULSE_US + 64'd999999) / 64'd1000000);
  localparam int unsigned CRG_HOST_WAIT_CYC =
    32'((CRG_CLK_HZ * CRG_HOST_WAIT_MS + 64'd999) / 64'd1000);

  typedef struct packed {
    logic [1:0] chargePhase;
    logic inputLimiting;
    logic thermalRegulating;
    logic vinAboveUvlo;
    logic vinOverVoltage;
    logic junctionHot;
    logic ntcOutOfRange;
    logic batOverVoltage;
    logic cellZeroUnder;
    logic cellOneUnder;
    logic decoderLow;
    logic chargeEvent;
    logic timerExpired;
    logic idleMode;
    logic charging;
    logic enPin;
  } crg_sense_t;

endpackage

// ===== crg_charger_control_status_regs.sv
// I2C target register bank of the boost charger control and status block
`timescale 1ns/1ns
`default_nettype none
module crg_charger_control_status_regs
  import crg_pkg::*;
#(
  parameter int unsigned VinPresentCycles = CRG_INPUT_PRESENT_FLAG_CYC,
  parameter int unsigned AdapterGoodCycles = CRG_ADAPTER_GOOD_CYC,
  parameter int unsigned WatchdogCycles = CRG_WATCHDOG_CYC,
  parameter int unsigned IntPulseCycles = CRG_INT_PULSE_CYC,
  parameter int unsigned HostWaitCycles = CRG_HOST_WAIT_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sclPin,
  input wire logic sdaPin,
  output var logic sdaOut_q,
  output var logic sdaOeN_q,
  input wire crg_sense_t sensePins,
  output var logic [5:0][7:0] cfg_q,
  output var logic intN_q,
  output var logic wdFault_q,
  output var logic timerRestart_q
);

  localparam int SW = $bits(crg_sense_t) + 2;
  localparam logic [SW-1:0] SYNC_RESET = {2'b11, {(SW - 2){1'b0}}};

  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_ACK_ADDR, S_PTR, S_ACK_PTR,
    S_WRITE, S_ACK_WRITE, S_READ, S_ACK_READ
  } crg_i2c_state_t;

  logic [SW-1:0] s1_q, s2_q, s3_q, in_q, prev_q;
  crg_sense_t sn, pv;
  logic scl, sda, sclPrev, sdaPrev, sclRise, sclFall, startCond, stopCond;
  logic busReady_q, rnw_q, wrStb_q, chgFault_q, vinPresent_q, adapter_good_flag_q;
  logic vinPresentPrev_q, wdExpire_q, intTrig, cmdWrite, timerRst, wdRst;
  logic regRst, enChg, enWd, ntcEnabled;
  logic [31:0] guardCnt_q, vinCnt_q, acokCnt_q, wdCnt_q, intCnt_q;
  crg_i2c_state_t st_q;
  logic [3:0] bit_q, fault_q, faultNow;
  logic [7:0] shift_q, tx_q, ptr_q, wrAddr_q, wrData_q, rdData, irqEn_q;
  logic [7:2] irq_q, irqSet, irqClr;
  logic [5:0][7:0] cfg_d;

  // Pins pass three flops; a bit moves only when stages two and three agree
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_q <= SYNC_RESET;
      s2_q <= SYNC_RESET;
      s3_q <= SYNC_RESET;
      in_q <= SYNC_RESET;
      prev_q <= SYNC_RESET;
    end else begin
      s1_q <= {sclPin, sdaPin, sensePins};
      s2_q <= s1_q;
      s3_q <= s2_q;
      in_q <= (s2_q & s3_q) | (in_q & (s2_q | s3_q));
      prev_q <= in_q;
    end
  end

  assign sn = in_q[SW-3:0];
  assign pv = prev_q[SW-3:0];
  assign scl = in_q[SW-1];
  assign sda = in_q[SW-2];
  assign sclPrev = prev_q[SW-1];
  assign sdaPrev = prev_q[SW-2];
  assign sclRise = scl & ~sclPrev;
  assign sclFall = ~scl & sclPrev;
  assign startCond = scl & sclPrev & sdaPrev & ~sda;
  assign stopCond = scl & sclPrev & ~sdaPrev & sda;

  // Bus stays deaf after reset or an enable pin rise
  always_ff @(posedge clk) begin
    if (reset || (sn.enPin && !pv.enPin)) begin
      guardCnt_q <= '0;
      busReady_q <= 1'b0;
    end else if (!busReady_q) begin
      if (guardCnt_q >= HostWaitCycles - 1) begin
        busReady_q <= 1'b1;
      end else begin
        guardCnt_q <= guardCnt_q + 32'd1;
      end
    end
  end

  // Register read view; unmapped offsets read zero
  always_comb begin
    rdData = 8'h00;
    if (ptr_q <= CRG_OFS_BALANCE_AND_COMMANDS) begin
      rdData = cfg_q[ptr_q[2:0]];
    end else if (ptr_q == CRG_OFS_CHARGE_STATE) begin
      rdData = {sn.chargePhase, sn.inputLimiting, sn.thermalRegulating,
                adapter_good_flag_q, vinPresent_q, 2'b00};
    end else if (ptr_q == CRG_OFS_FAULT_FLAGS) begin
      rdData = {fault_q, chgFault_q, wdFault_q, 2'b00};
    end else if (ptr_q == CRG_OFS_INTERRUPT_REQUESTS) begin
      rdData = {irq_q, 2'b00};
    end else if (ptr_q == CRG_OFS_INTERRUPT_ENABLES) begin
      rdData = irqEn_q;
    end
  end

  // I2C target; the line is only pulled low, never driven high
  always_ff @(posedge clk) begin
    wrStb_q <= 1'b0;
    sdaOut_q <= 1'b0;
    if (reset || stopCond || !busReady_q) begin
      st_q <= S_IDLE;
      sdaOeN_q <= 1'b1;
      bit_q <= '0;
      shift_q <= '0;
      tx_q <= '0;
      rnw_q <= 1'b0;
      wrAddr_q <= '0;
      wrData_q <= '0;
      if (reset) begin
        ptr_q <= '0;
      end
    end else if (startCond) begin
      st_q <= S_ADDR;
      bit_q <= '0;
      sdaOeN_q <= 1'b1;
    end else if (sclRise) begin
      shift_q <= {shift_q[6:0], sda};
      bit_q <= bit_q + 4'd1;
      if (st_q == S_ACK_READ && sda) begin
        st_q <= S_IDLE;
      end
    end else if (sclFall) begin
      case (st_q)
        S_ADDR: begin
          if (bit_q == 4'd8) begin
            if (shift_q[7:1] == CRG_I2C_ADDR) begin
              st_q <= S_ACK_ADDR;
              rnw_q <= shift_q[0];
              sdaOeN_q <= 1'b0;
            end else begin
              st_q <= S_IDLE;
            end
          end
        end
        S_ACK_ADDR: begin
          bit_q <= '0;
          if (rnw_q) begin
            st_q <= S_READ;
            tx_q <= rdData;
            sdaOeN_q <= rdData[7];
          end else begin
            st_q <= S_PTR;
            sdaOeN_q <= 1'b1;
          end
        end
        S_PTR: begin
          if (bit_q == 4'd8) begin
            ptr_q <= shift_q;
            st_q <= S_ACK_PTR;
            sdaOeN_q <= 1'b0;
          end
        end
        S_ACK_PTR, S_ACK_WRITE: begin
          st_q <= S_WRITE;
          bit_q <= '0;
          sdaOeN_q <= 1'b1;
        end
        S_WRITE: begin
          if (bit_q == 4'd8) begin
            wrStb_q <= 1'b1;
            wrAddr_q <= ptr_q;
            wrData_q <= shift_q;
            ptr_q <= ptr_q + 8'd1;
            st_q <= S_ACK_WRITE;
            sdaOeN_q <= 1'b0;
          end
        end
        S_READ: begin
          if (bit_q == 4'd8) begin
            ptr_q <= ptr_q + 8'd1;
            st_q <= S_ACK_READ;
            sdaOeN_q <= 1'b1;
          end else begin
            sdaOeN_q <= tx_q[3'd7 - bit_q[2:0]];
          end
        end
        S_ACK_READ: begin
          st_q <= S_READ;
          bit_q <= '0;
          tx_q <= rdData;
          sdaOeN_q <= rdData[7];
        end
        default: begin
          sdaOeN_q <= 1'b1;
        end
      endcase
    end
  end

  // Command bits are decoded from the write and never stored
  assign cmdWrite = wrStb_q && wrAddr_q == CRG_OFS_BALANCE_AND_COMMANDS;
  assign timerRst = cmdWrite && wrData_q[CRG_POS_TIMER_RST];
  assign wdRst = cmdWrite && wrData_q[CRG_POS_WATCHDOG_RESTART_COMMAND];
  assign regRst = cmdWrite && wrData_q[CRG_POS_REG_RST];
  assign enChg = cfg_q[4][CRG_POS_CHARGE_ENABLE_BIT];
  assign enWd = cfg_q[4][CRG_POS_WATCHDOG_ENABLE_BIT];
  assign ntcEnabled = |cfg_q[3][7:4];

  // Later terms win: write, then watchdog restore, then input-absent hold
  always_comb begin
    cfg_d = cfg_q;
    for (int i = 0; i < 6; i++) begin
      if (wrStb_q && wrAddr_q == 8'(i)) begin
        cfg_d[i] = (wrData_q & CRG_WMASK[i]) |
                   (cfg_q[i] & ~CRG_WMASK[i]);
      end
      if (wdExpire_q) begin
        cfg_d[i] = (cfg_d[i] & ~CRG_WDMASK[i]) |
                   (CRG_RESET[i] & CRG_WDMASK[i]);
      end
      if (!vinPresent_q) begin
        cfg_d[i] = (cfg_d[i] & ~CRG_VINMASK[i]) |
                   (CRG_RESET[i] & CRG_VINMASK[i]);
      end
    end
    if (sn.decoderLow || cfg_d[0][CRG_POS_TARGET_HI]) begin
      cfg_d[3][1:0] = 2'b00;
    end
    if (sn.cellOneUnder || cfg_d[3][1:0] == 2'b00) begin
      cfg_d[3][CRG_POS_BAL1] = 1'b0;
    end
    if (sn.cellZeroUnder || cfg_d[3][1:0] == 2'b00) begin
      cfg_d[3][CRG_POS_BAL0] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || regRst) begin
      cfg_q <= CRG_RESET;
      irqEn_q <= CRG_IRQ_EN_RESET;
    end else begin
      cfg_q <= cfg_d;
      if (wrStb_q && wrAddr_q == CRG_OFS_INTERRUPT_ENABLES) begin
        irqEn_q <= wrData_q;
      end
    end
  end

  // Input present and adapter good qualify on long stable windows
  always_ff @(posedge clk) begin
    if (reset || !sn.vinAboveUvlo) begin
      vinCnt_q <= '0;
      vinPresent_q <= 1'b0;
    end else if (!vinPresent_q) begin
      if (vinCnt_q >= VinPresentCycles - 1) begin
        vinPresent_q <= 1'b1;
      end else begin
        vinCnt_q <= vinCnt_q + 32'd1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset || !vinPresent_q || sn.vinOverVoltage) begin
      acokCnt_q <= '0;
      adapter_good_flag_q <= 1'b0;
    end else if (!adapter_good_flag_q) begin
      if (acokCnt_q >= AdapterGoodCycles - 1) begin
        adapter_good_flag_q <= 1'b1;
      end else begin
        acokCnt_q <= acokCnt_q + 32'd1;
      end
    end
  end

  // Live fault flags follow their conditions; NTC counts only while a hot or cold threshold is enabled
  assign faultNow = {sn.vinOverVoltage, sn.junctionHot,
                     sn.ntcOutOfRange & ntcEnabled,
                     sn.batOverVoltage};

  always_ff @(posedge clk) begin
    if (reset) begin
      fault_q <= '0;
      vinPresentPrev_q <= 1'b0;
      timerRestart_q <= 1'b0;
    end else begin
      fault_q <= faultNow;
      vinPresentPrev_q <= vinPresent_q;
      timerRestart_q <= timerRst;
    end
  end

  // A new expiry in the same cycle as a clearing event still sets the flag
  always_ff @(posedge clk) begin
    if (reset) begin
      chgFault_q <= 1'b0;
    end else if (sn.timerExpired && !pv.timerExpired) begin
      chgFault_q <= 1'b1;
    end else if (timerRst || cfg_q[1][7:6] == 2'b00 || !sn.enPin ||
                 !enChg || sn.idleMode) begin
      chgFault_q <= 1'b0;
    end
  end

  // Watchdog runs only while charging with the enable set
  always_ff @(posedge clk) begin
    wdExpire_q <= 1'b0;
    if (reset || wdRst || !enWd || !sn.charging || wdFault_q) begin
      wdCnt_q <= '0;
    end else if (wdCnt_q >= WatchdogCycles - 1) begin
      wdCnt_q <= '0;
      wdExpire_q <= 1'b1;
    end else begin
      wdCnt_q <= wdCnt_q + 32'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wdFault_q <= 1'b0;
    end else if (wdExpire_q) begin
      wdFault_q <= 1'b1;
    end else if (wdRst || !enWd) begin
      wdFault_q <= 1'b0;
    end
  end

  // Request flags; a set in the clearing cycle wins
  assign irqSet = {faultNow & ~fault_q, vinPresent_q ^ vinPresentPrev_q,
                   sn.chargeEvent & ~pv.chargeEvent};
  assign irqClr = (wrStb_q && wrAddr_q == CRG_OFS_INTERRUPT_REQUESTS) ?
                  wrData_q[7:2] : 6'h00;

  always_ff @(posedge clk) begin
    if (reset || regRst) begin
      irq_q <= '0;
    end else begin
      irq_q <= (irq_q & ~irqClr) | irqSet;
    end
  end

  assign intTrig = |(irqSet & ~irq_q & irqEn_q[7:2]) ||
                   (sn.timerExpired && !pv.timerExpired && !chgFault_q &&
                    irqEn_q[CRG_POS_IRQ_CHG_EN]) ||
                   (wdExpire_q && !wdFault_q &&
                    irqEn_q[CRG_POS_IRQ_WD_EN]);

  // A new trigger restarts the low pulse rather than queueing another
  always_ff @(posedge clk) begin
    if (reset) begin
      intCnt_q <= '0;
      intN_q <= 1'b1;
    end else if (intTrig) begin
      intCnt_q <= IntPulseCycles - 1;
      intN_q <= 1'b0;
    end else if (intCnt_q != 32'd0) begin
      intCnt_q <= intCnt_q - 32'd1;
    end else begin
      intN_q <= 1'b1;
    end
  end

endmodule // crg_charger_control_status_regs
`default_nettype wire

// ===== crg_regs_chk.sv
// Port-level assertions for the charger register bank
`timescale 1ns/1ns
`default_nettype none
module crg_regs_chk
  import crg_pkg::*;
#(
  parameter int unsigned IntPulseCycles = CRG_INT_PULSE_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sdaOeN_q,
  input wire crg_sense_t sensePins,
  input wire logic [5:0][7:0] cfg_q,
  input wire logic intN_q,
  input wire logic wdFault_q,
  input wire logic timerRestart_q
);
  // Length of the current low stretch on the interrupt output
  logic [15:0] lowCnt_q;
  always_ff @(posedge clk) begin
    if (reset || intN_q) begin
      lowCnt_q <= 16'h0000;
    end else begin
      lowCnt_q <= lowCnt_q + 16'h0001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Reset checks must run while reset is high, so they drop the default
  AST_RESET_OUT: assert property (disable iff (1'b0) reset |=>
    intN_q && !wdFault_q && !timerRestart_q && sdaOeN_q)
    else $error("outputs not idle after reset");
  AST_RESET_CFG: assert property (disable iff (1'b0) reset |=>
    cfg_q == CRG_RESET) else $error("config not at defaults after reset");
  AST_CMD_ZERO: assert property (cfg_q[5][2:0] == 3'b000)
    else $error("command bits read back nonzero");
  AST_RESERVED: assert property (cfg_q[0][1:0] == 2'b00 &&
    cfg_q[4][7] == 1'b0 && cfg_q[4][1:0] == 2'b00 && cfg_q[5][3] == 1'b0)
    else $error("reserved bit set");
  AST_TR_ONE: assert property (timerRestart_q |=> !timerRestart_q)
    else $error("timer restart longer than one cycle");
  AST_INT_WIDTH: assert property ($rose(intN_q) |->
    lowCnt_q >= IntPulseCycles) else $error("interrupt pulse too short");
  AST_BAL_TARGET: assert property (cfg_q[0][7] [*3] |->
    cfg_q[3][1:0] == 2'b00) else $error("balance mode kept above 12V");
  AST_CELL_UNDER: assert property (sensePins.cellZeroUnder [*6] |->
    !cfg_q[3][2]) else $error("cell balance kept on undervoltage");
  AST_MODE_OFF: assert property ((cfg_q[3][1:0] == 2'b00) [*3] |->
    cfg_q[3][3:2] == 2'b00) else $error("balance switch on with mode off");
  AST_WD_FIELDS: assert property ($rose(wdFault_q) |-> ##[0:1]
    (cfg_q[0] == CRG_RESET[0] && cfg_q[4][4]))
    else $error("watchdog expiry field restore wrong");
  AST_ABSENT: assert property (!sensePins.vinAboveUvlo [*8] |->
    cfg_q[1] == CRG_RESET[1]) else $error("config kept without input");
  cover property ($fell(intN_q));
  cover property ($rose(wdFault_q));
  cover property (timerRestart_q);
endmodule // crg_regs_chk
bind crg_charger_control_status_regs crg_regs_chk #(
  .IntPulseCycles(IntPulseCycles)
) crg_regs_chk_inst (
  .clk(clk),
  .reset(reset),
  .sdaOeN_q(sdaOeN_q),
  .sensePins(sensePins),
  .cfg_q(cfg_q),
  .intN_q(intN_q),
  .wdFault_q(wdFault_q),
  .timerRestart_q(timerRestart_q)
);
`default_nettype wire

// ===== crg_host_model.sv
// I2C controller model playing the host side of the register bank
`timescale 1ns/1ns
`default_nettype none
module crg_host_model
  import crg_pkg::*;
(
  input wire logic clk,
  input wire logic sdaPin,
  output var logic sclPin,
  output var logic sdaHost
);
  // Twelve cycles a half period stays clear of the eight-cycle minimum
  localparam int Half = 12;
  int nackCount = 0;
  initial begin
    sclPin = 1'b1;
    sdaHost = 1'b1;
  end
  task automatic hw();
    repeat (Half) @(posedge clk);
    #1;
  endtask
  // Data moves inside the low phase, never beside an SCL edge
  task automatic clockBit(input logic b, output logic s);
    repeat (4) @(posedge clk);
    #1;
    sdaHost = b;
    hw();
    sclPin = 1'b1;
    hw();
    s = sdaPin;
    sclPin = 1'b0;
  endtask
  task automatic start();
    hw();
    sdaHost = 1'b1;
    hw();
    sclPin = 1'b1;
    hw();
    sdaHost = 1'b0;
    hw();
    sclPin = 1'b0;
  endtask
  task automatic stop();
    hw();
    sdaHost = 1'b0;
    hw();
    sclPin = 1'b1;
    hw();
    sdaHost = 1'b1;
    hw();
  endtask
  task automatic sendByte(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clockBit(d[i], s);
    end
    clockBit(1'b1, s);
    if (s !== 1'b0) begin
      nackCount++;
    end
  endtask
  task automatic probe(input logic [6:0] a, output logic acked);
    int n;
    n = nackCount;
    start();
    sendByte({a, 1'b0});
    stop();
    acked = (nackCount == n);
    nackCount = n;
  endtask
  task automatic writeReg(input logic [7:0] a, input logic [7:0] d);
    start();
    sendByte({CRG_I2C_ADDR, 1'b0});
    sendByte(a);
    sendByte(d);
    stop();
  endtask
  task automatic readReg(input logic [7:0] a, output logic [7:0] d);
    logic s;
    start();
    sendByte({CRG_I2C_ADDR, 1'b0});
    sendByte(a);
    start();
    sendByte({CRG_I2C_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) begin
      clockBit(1'b1, d[i]);
    end
    clockBit(1'b1, s);
    stop();
  endtask
endmodule // crg_host_model
`default_nettype wire

// ===== crg_charger_control_status_regs_tb.sv
// Self-checking testbench for the charger register bank
`timescale 1ns/1ns
`default_nettype none
module crg_charger_control_status_regs_tb;
  import crg_pkg::*;
  localparam int WdCyc = 200;
  localparam int Limit = 80000;
  logic clk, reset, sclPin, sdaHost, sdaPin, ack;
  logic sdaOut_q, sdaOeN_q, intN_q, wdFault_q, timerRestart_q, intPrev;
  crg_sense_t sensePins;
  logic [5:0][7:0] cfg_q;
  logic [7:0] intFalls = 8'h00;
  logic [7:0] trCount = 8'h00;
  logic [7:0] intBase, trBase;
  int fails = 0;
  int totalChecks = 0;
  int cycles = 0;
  logic [7:0] expTab [11] = '{8'h2c, 8'hd8, 8'h89, 8'h51, 8'h64, 8'h00,
    8'hac, 8'h00, 8'h08, 8'hff, 8'h00};
  // Open-drain data line with pull-up: low if either side pulls it
  assign sdaPin = sdaHost & (sdaOeN_q ? 1'b1 : sdaOut_q);
  crg_charger_control_status_regs #(
    .VinPresentCycles(20),
    .AdapterGoodCycles(10),
    .WatchdogCycles(WdCyc),
    .IntPulseCycles(16),
    .HostWaitCycles(8)
  ) crg_charger_control_status_regs_inst (
    .clk(clk),
    .reset(reset),
    .sclPin(sclPin),
    .sdaPin(sdaPin),
    .sdaOut_q(sdaOut_q),
    .sdaOeN_q(sdaOeN_q),
    .sensePins(sensePins),
    .cfg_q(cfg_q),
    .intN_q(intN_q),
    .wdFault_q(wdFault_q),
    .timerRestart_q(timerRestart_q)
  );
  crg_host_model crg_host_model_inst (
    .clk(clk),
    .sdaPin(sdaPin),
    .sclPin(sclPin),
    .sdaHost(sdaHost)
  );
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    intPrev <= intN_q;
    if (intPrev === 1'b1 && intN_q === 1'b0) begin
      intFalls++;
    end
    if (timerRestart_q === 1'b1) begin
      trCount++;
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == Limit) begin
      fails++;
      finish_test();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic checkByte(input logic [7:0] got, input logic [7:0] exp);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic checkFlag(input logic got, input logic exp);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    crg_host_model_inst.writeReg(a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    crg_host_model_inst.readReg(a, v);
    checkByte(v, exp);
  endtask
  initial begin
    reset = 1'b1;
    sensePins = '0;
    sensePins.enPin = 1'b1;
    sensePins.chargePhase = 2'b10;
    sensePins.inputLimiting = 1'b1;
    cyc(20);
    reset = 1'b0;
    cyc(12);
    sensePins.vinAboveUvlo = 1'b1;
    cyc(60);
    for (int i = 0; i < 6; i++) begin
      checkByte(cfg_q[i], CRG_RESET[i]);
    end
    for (int i = 0; i < 11; i++) begin
      rd(8'(i), expTab[i]);
    end
    crg_host_model_inst.probe(7'h6a, ack);
    checkFlag(ack, 1'b0);
    checkFlag(sdaOut_q, 1'b0);
    wr(8'h03, 8'h5d);
    rd(8'h03, 8'h5d);
    sensePins.cellZeroUnder = 1'b1;
    cyc(10);
    checkByte(cfg_q[3], 8'h59);
    sensePins.cellZeroUnder = 1'b0;
    wr(8'h00, 8'hff);
    rd(8'h00, 8'hfc);
    checkByte(cfg_q[3], 8'h50);
    wr(8'h04, 8'hff);
    rd(8'h04, 8'h7c);
    wr(8'h09, 8'h00);
    wr(8'h05, 8'h01);
    rd(8'h00, 8'h2c);
    rd(8'h03, 8'h51);
    rd(8'h04, 8'h64);
    rd(8'h05, 8'h00);
    rd(8'h09, 8'hff);
    intBase = intFalls;
    sensePins.vinOverVoltage = 1'b1;
    cyc(40);
    checkByte(intFalls - intBase, 8'h01);
    rd(8'h07, 8'h80);
    rd(8'h08, 8'h80);
    sensePins.vinOverVoltage = 1'b0;
    cyc(10);
    rd(8'h07, 8'h00);
    wr(8'h08, 8'h80);
    rd(8'h08, 8'h00);
    wr(8'h09, 8'hbf);
    intBase = intFalls;
    sensePins.junctionHot = 1'b1;
    cyc(40);
    checkByte(intFalls - intBase, 8'h00);
    rd(8'h08, 8'h40);
    sensePins.chargeEvent = 1'b1;
    sensePins.batOverVoltage = 1'b1;
    cyc(10);
    rd(8'h07, 8'h50);
    rd(8'h08, 8'h54);
    sensePins.chargeEvent = 1'b0;
    sensePins.batOverVoltage = 1'b0;
    sensePins.junctionHot = 1'b0;
    sensePins.charging = 1'b1;
    sensePins.timerExpired = 1'b1;
    cyc(10);
    rd(8'h07, 8'h08);
    trBase = trCount;
    wr(8'h05, 8'h04);
    checkByte(trCount - trBase, 8'h01);
    rd(8'h07, 8'h00);
    sensePins.timerExpired = 1'b0;
    wr(8'h02, 8'h00);
    wr(8'h00, 8'h4c);
    wr(8'h04, 8'h18);
    cyc(WdCyc + 40);
    checkFlag(wdFault_q, 1'b1);
    checkByte(cfg_q[0], 8'h2c);
    checkByte(cfg_q[2], 8'h09);
    checkByte(cfg_q[4], 8'h74);
    rd(8'h07, 8'h04);
    sensePins.charging = 1'b0;
    wr(8'h05, 8'h02);
    checkFlag(wdFault_q, 1'b0);
    rd(8'h07, 8'h00);
    wr(8'h01, 8'h00);
    sensePins.vinAboveUvlo = 1'b0;
    cyc(10);
    checkByte(cfg_q[1], 8'hd8);
    checkByte(8'(crg_host_model_inst.nackCount), 8'h00);
    finish_test();
  end
endmodule // crg_charger_control_status_regs_tb
`default_nettype wire
